/* t1p_pkg.sv */
// constants and types for the timer1 interrupt flag and prescaler block
package t1p_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] T1P_FLAGS_DATA_ADDR = 8'h36;
    localparam logic [7:0] T1P_IO_ADDR_OFFSET  = 8'h20;
    localparam logic [7:0] T1P_FLAGS_IO_ADDR   = T1P_FLAGS_DATA_ADDR - T1P_IO_ADDR_OFFSET;
    localparam logic [7:0] T1P_MASK_DATA_ADDR  = 8'h6F;
    localparam logic [7:0] T1P_FLAGS_RESET     = 8'h00;
    localparam logic [7:0] T1P_MASK_RESET      = 8'h00;
    localparam logic [7:0] T1P_RDATA_RESET     = 8'h00;

    // ----------------------------------------------------------------
    // field positions, shared by mask and flag registers
    // ----------------------------------------------------------------
    localparam int unsigned T1P_CAPTURE_BIT = 5;
    localparam int unsigned T1P_MATCH_B_BIT = 2;
    localparam int unsigned T1P_MATCH_A_BIT = 1;
    localparam int unsigned T1P_WRAP_BIT    = 0;
    localparam logic [7:0]  T1P_IMPL_BITS   = 8'h27;

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    localparam int unsigned T1P_PRESCALE_W = 10;
    localparam int unsigned T1P_TAP8_W     = 3;
    localparam int unsigned T1P_TAP64_W    = 6;
    localparam int unsigned T1P_TAP256_W   = 8;
    localparam int unsigned T1P_TAP1024_W  = 10;
    localparam logic [T1P_PRESCALE_W-1:0] T1P_PRESCALE_RESET = 10'h000;

    // ----------------------------------------------------------------
    // clock select codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        T1P_CS_STOP     = 3'h0,
        T1P_CS_SYS      = 3'h1,
        T1P_CS_DIV8     = 3'h2,
        T1P_CS_DIV64    = 3'h3,
        T1P_CS_DIV256   = 3'h4,
        T1P_CS_DIV1024  = 3'h5,
        T1P_CS_EXT_FALL = 3'h6,
        T1P_CS_EXT_RISE = 3'h7
    } t1p_clk_sel_t;

endpackage : t1p_pkg

/* t1p_top.sv */
// timer1 interrupt mask/flags and the shared timer0/timer1 clock front end
//
// Overview of operation
// - capture irq needs enable bit5, I-flag, flag
// - match B irq needs bit2, I-flag, flag
// - match A irq needs bit1, I-flag, flag
// - wrap irq needs bit0, I-flag, flag
// - capture flag on pin event, or TOP
// - capture flag cleared by vector or one
// - match B flag set tick after equality
// - match A flag set tick after equality
// - forced compare strobes never set flags
// - match flags cleared by vector or one
// - wrap flag on overflow, else mode event
// - wrap flag cleared by vector or one
// - flags at 0x36, I/O alias 0x16
// - select 0x1 counts every system clock
// - prescaler taps divide by 8,64,256,1024
// - prescaler free running, shared by both timers
// - first prescaled count within 1..N cycles
// - prescaler reset restarts both timers' period
// - count pin sampled each cycle, then edge-detected
// - latch transparent high, then rising-edge registers
// - one tick per rise (0x7) or fall (0x6)
// - external edge to count 2.5..3.5 cycles
// - external clock never prescaled
// - counter write blocks next-tick compare flags
`timescale 1ns/1ns

module t1p_top
    import t1p_pkg::*;
#(
    parameter logic [15:0] CAPTURE_TOP_MODES = 16'h5500,
    parameter logic [15:0] WRAP_OVF_MODES    = 16'h1011
)
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // cpu register access
    input  wire logic [7:0]           reg_addr,
    input  wire logic                 reg_io_space,
    input  wire logic                 reg_wr_en,
    input  wire logic                 reg_rd_en,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata_q,
    // cpu interrupt side
    input  wire logic                 global_irq_enable,
    input  wire logic                 capture_vector_ack,
    input  wire logic                 match_b_vector_ack,
    input  wire logic                 match_a_vector_ack,
    input  wire logic                 wrap_vector_ack,
    output logic                      capture_irq_req_q,
    output logic                      match_b_irq_req_q,
    output logic                      match_a_irq_req_q,
    output logic                      wrap_irq_req_q,
    // timer1 datapath events
    input  wire logic [3:0]           waveform_mode_field,
    input  wire logic                 capture_pin_event,
    input  wire logic                 counter_top_event,
    input  wire logic                 counter_overflow,
    input  wire logic                 mode_wrap_event,
    input  wire logic                 match_a_equal,
    input  wire logic                 match_b_equal,
    input  wire logic                 force_match_a_strobe,
    input  wire logic                 force_match_b_strobe,
    input  wire logic                 count_write,
    // clock front end, index 0 = timer0, index 1 = timer1
    input  wire t1p_pkg::t1p_clk_sel_t timer0_clock_select,
    input  wire t1p_pkg::t1p_clk_sel_t timer1_clock_select,
    input  wire logic [1:0]           external_count_pin,
    input  wire logic                 prescaler_reset,
    output logic      [1:0]           timer_tick_q
);
    import t1p_pkg::*;

    // ----------------------------------------------------------------
    // shared prescaler
    // ----------------------------------------------------------------
    logic [T1P_PRESCALE_W-1:0] prescale_q;
    logic                      tap8;
    logic                      tap64;
    logic                      tap256;
    logic                      tap1024;

    // free running, never looks at either clock select
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            prescale_q <= T1P_PRESCALE_RESET;
        else if (prescaler_reset)
            prescale_q <= T1P_PRESCALE_RESET;
        else
            prescale_q <= prescale_q + 10'h001;
    end

    // a tap fires on the last count of its period
    assign tap8    = &prescale_q[T1P_TAP8_W-1:0];
    assign tap64   = &prescale_q[T1P_TAP64_W-1:0];
    assign tap256  = &prescale_q[T1P_TAP256_W-1:0];
    assign tap1024 = &prescale_q[T1P_TAP1024_W-1:0];

    // ----------------------------------------------------------------
    // per-timer clock select and count pin front end
    // ----------------------------------------------------------------
    t1p_clk_sel_t clk_sel [2];
    assign clk_sel[0] = timer0_clock_select;
    assign clk_sel[1] = timer1_clock_select;

    for (genvar t = 0; t < 2; t++)
    begin : g_tmr
        logic pin_latch;
        logic sync1_q;
        logic sync2_q;
        logic prev_q;
        logic rise;
        logic fall;
        logic tick_d;

        // transparent in the high phase, halves the metastability window
        always_latch
        begin
            if (ref_clk)
                pin_latch = external_count_pin[t];
        end

        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                sync1_q <= 1'b0;
                sync2_q <= 1'b0;
                prev_q  <= 1'b0;
            end
            else
            begin
                sync1_q <= pin_latch;
                sync2_q <= sync1_q;
                prev_q  <= sync2_q;
            end
        end

        assign rise = sync2_q & ~prev_q;
        assign fall = ~sync2_q & prev_q;

        always_comb
        begin
            case (clk_sel[t])
                T1P_CS_STOP:     tick_d = 1'b0;
                T1P_CS_SYS:      tick_d = 1'b1;
                T1P_CS_DIV8:     tick_d = tap8;
                T1P_CS_DIV64:    tick_d = tap64;
                T1P_CS_DIV256:   tick_d = tap256;
                T1P_CS_DIV1024:  tick_d = tap1024;
                T1P_CS_EXT_FALL: tick_d = fall;
                T1P_CS_EXT_RISE: tick_d = rise;
                default:         tick_d = 1'b0;
            endcase
        end

        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
                timer_tick_q[t] <= 1'b0;
            else
                timer_tick_q[t] <= tick_d;
        end
    end

    // ----------------------------------------------------------------
    // register access decode
    // ----------------------------------------------------------------
    logic       hit_flags;
    logic       hit_mask;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] mask_q;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic       tick1;
    logic       block_q;
    logic       icr_top;
    logic       wrap_on_ovf;

    // I/O instructions see the same register 0x20 lower; mask has no alias
    assign hit_flags = reg_io_space ? (reg_addr == T1P_FLAGS_IO_ADDR)
                                    : (reg_addr == T1P_FLAGS_DATA_ADDR);
    assign hit_mask  = !reg_io_space && (reg_addr == T1P_MASK_DATA_ADDR);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_q <= T1P_MASK_RESET;
        else if (reg_wr_en && hit_mask)
            mask_q <= reg_wdata & T1P_IMPL_BITS;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_q <= T1P_RDATA_RESET;
        else if (reg_rd_en)
            reg_rdata_q <= hit_flags ? flags_q : (hit_mask ? mask_q : 8'h00);
    end

    // ----------------------------------------------------------------
    // flag set events
    // ----------------------------------------------------------------
    assign tick1       = timer_tick_q[1];
    assign icr_top     = CAPTURE_TOP_MODES[waveform_mode_field];
    assign wrap_on_ovf = WRAP_OVF_MODES[waveform_mode_field];

    // a counter write kills the match seen on the following timer tick
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            block_q <= 1'b0;
        else
            block_q <= count_write | (block_q & ~tick1);
    end

    // forced strobes are deliberately absent from these terms
    always_comb
    begin
        flag_set = 8'h00;
        flag_set[T1P_CAPTURE_BIT] = icr_top ? counter_top_event
                                            : capture_pin_event;
        flag_set[T1P_MATCH_B_BIT] = tick1 & match_b_equal & ~block_q;
        flag_set[T1P_MATCH_A_BIT] = tick1 & match_a_equal & ~block_q;
        flag_set[T1P_WRAP_BIT]    = wrap_on_ovf ? counter_overflow
                                                : mode_wrap_event;
    end

    always_comb
    begin
        flag_clr = (reg_wr_en && hit_flags) ? reg_wdata : 8'h00;
        flag_clr[T1P_CAPTURE_BIT] = flag_clr[T1P_CAPTURE_BIT] | capture_vector_ack;
        flag_clr[T1P_MATCH_B_BIT] = flag_clr[T1P_MATCH_B_BIT] | match_b_vector_ack;
        flag_clr[T1P_MATCH_A_BIT] = flag_clr[T1P_MATCH_A_BIT] | match_a_vector_ack;
        flag_clr[T1P_WRAP_BIT]    = flag_clr[T1P_WRAP_BIT] | wrap_vector_ack;
    end

    // set wins over clear so an event in the clearing cycle survives
    assign flags_d = ((flags_q & ~flag_clr) | flag_set) & T1P_IMPL_BITS;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            flags_q <= T1P_FLAGS_RESET;
        else
            flags_q <= flags_d;
    end

    // ----------------------------------------------------------------
    // interrupt requests
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            capture_irq_req_q <= 1'b0;
            match_b_irq_req_q <= 1'b0;
            match_a_irq_req_q <= 1'b0;
            wrap_irq_req_q    <= 1'b0;
        end
        else
        begin
            capture_irq_req_q <= global_irq_enable & mask_q[T1P_CAPTURE_BIT]
                               & flags_q[T1P_CAPTURE_BIT];
            match_b_irq_req_q <= global_irq_enable & mask_q[T1P_MATCH_B_BIT]
                               & flags_q[T1P_MATCH_B_BIT];
            match_a_irq_req_q <= global_irq_enable & mask_q[T1P_MATCH_A_BIT]
                               & flags_q[T1P_MATCH_A_BIT];
            wrap_irq_req_q    <= global_irq_enable & mask_q[T1P_WRAP_BIT]
                               & flags_q[T1P_WRAP_BIT];
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_cap_armed;
        global_irq_enable && mask_q[T1P_CAPTURE_BIT] && flags_q[T1P_CAPTURE_BIT];
    endsequence
    property p_cap_irq;
        capture_irq_req_q |-> $past(global_irq_enable && mask_q[5] && flags_q[5]);
    endproperty
    a_cap_irq: assert property (p_cap_irq)
        else $error("capture irq without enable and flag");
    property p_cap_irq_rise;
        s_cap_armed |=> capture_irq_req_q;
    endproperty
    a_cap_irq_rise: assert property (p_cap_irq_rise)
        else $error("capture irq missing");
    property p_mb_irq;
        match_b_irq_req_q |-> $past(global_irq_enable && mask_q[2] && flags_q[2]);
    endproperty
    a_mb_irq: assert property (p_mb_irq)
        else $error("match b irq without enable and flag");
    property p_ma_irq;
        (global_irq_enable && mask_q[1] && flags_q[1]) |=> match_a_irq_req_q;
    endproperty
    a_ma_irq: assert property (p_ma_irq)
        else $error("match a irq missing");
    property p_wrap_irq;
        !global_irq_enable |=> !wrap_irq_req_q;
    endproperty
    a_wrap_irq: assert property (p_wrap_irq)
        else $error("wrap irq with interrupts disabled");

    property p_cap_set;
        capture_pin_event && !icr_top |=> flags_q[T1P_CAPTURE_BIT];
    endproperty
    a_cap_set: assert property (p_cap_set)
        else $error("capture flag not set by pin event");

    sequence s_match_a_hit;
        tick1 && match_a_equal && !block_q;
    endsequence
    property p_match_a_set;
        s_match_a_hit |=> flags_q[T1P_MATCH_A_BIT];
    endproperty
    a_match_a_set: assert property (p_match_a_set)
        else $error("match a flag not set");

    property p_force_b;
        force_match_b_strobe && !tick1 && !flags_q[2] |=> !flags_q[2];
    endproperty
    a_force_b: assert property (p_force_b)
        else $error("forced strobe set match b flag");

    property p_block;
        count_write ##1 (tick1 && !flags_q[1]) |=> !flags_q[1];
    endproperty
    a_block: assert property (p_block)
        else $error("match flag set after counter write");

    property p_w1c;
        reg_wr_en && hit_flags && reg_wdata[0] && !flag_set[0] |=> !flags_q[0];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("wrap flag not cleared by write one");

    property p_set_wins;
        capture_vector_ack && flag_set[5] |=> flags_q[5];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("set lost against clear");

    property p_sys_tick;
        timer1_clock_select == T1P_CS_SYS |=> timer_tick_q[1];
    endproperty
    a_sys_tick: assert property (p_sys_tick)
        else $error("system clock select does not tick");

    // a prescaler reset in the same cycle restarts the period, so it is left out
    sequence s_div8_start;
        $changed(timer1_clock_select) && timer1_clock_select == T1P_CS_DIV8
            && !prescaler_reset;
    endsequence
    property p_div8_first;
        s_div8_start |-> ##[1:8] timer_tick_q[1];
    endproperty
    a_div8_first: assert property (p_div8_first)
        else $error("first divide by 8 tick late");

    sequence s_ext_rise_stable;
        (timer1_clock_select == T1P_CS_EXT_RISE && !prescaler_reset)[*4];
    endsequence
    property p_ext_delay;
        $rose(external_count_pin[1]) ##0 s_ext_rise_stable |-> timer_tick_q[1]
            || $past(timer_tick_q[1], 1);
    endproperty
    a_ext_delay: assert property (p_ext_delay)
        else $error("external edge not counted in time");

    property p_reg_zero;
        reg_rd_en |=> (reg_rdata_q & ~T1P_IMPL_BITS) == 8'h00;
    endproperty
    a_reg_zero: assert property (p_reg_zero)
        else $error("unused register bits read nonzero");

endmodule : t1p_top

/* t1p_ext_src.sv */
// model of the external count pulse source feeding both count pins
`timescale 1ns/1ns

module t1p_ext_src (
    // clock
    input  wire logic       ref_clk,
    // count pins, [0] timer0, [1] timer1
    output logic      [1:0] ext_pin
);
    initial ext_pin = 2'h0;

    // each level held 'half' cycles; a half period of one cycle could be missed
    task automatic pulses(input int n, input int half);
        repeat (n)
        begin
            @(posedge ref_clk);
            ext_pin <= 2'h3;
            repeat (half) @(posedge ref_clk);
            ext_pin <= 2'h0;
            repeat (half - 1) @(posedge ref_clk);
        end
    endtask : pulses
endmodule : t1p_ext_src

/* tb_top.sv */
// self-checking testbench for the timer1 flag and prescaler block
`timescale 1ns/1ns

module tb_top;
    import t1p_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and observation
    // ----------------------------------------------------------------
    logic         ref_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic [7:0]   reg_addr = 8'h00;
    logic [7:0]   reg_wdata = 8'h00;
    logic         reg_io = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, gie = 1'b0;
    logic [3:0]   ack = 4'h0;
    logic [3:0]   wmode = 4'h0;
    logic [5:0]   ev = 6'h00;
    logic [1:0]   frc = 2'h0;
    logic         cwr = 1'b0, psc_rst = 1'b0;
    t1p_clk_sel_t sel0 = T1P_CS_STOP, sel1 = T1P_CS_STOP;
    wire  [1:0]   ext_pin;
    logic [7:0]   rdata;
    logic         irq_c, irq_b, irq_a, irq_w;
    logic [1:0]   tick;
    int           err_total = 0, checked = 0;
    int           ticks[2] = '{0, 0};
    int           t0[2];
    int           dv[6] = '{0, 1, 8, 64, 256, 1024};

    initial forever #50 ref_clk = ~ref_clk;
    always @(negedge ref_clk) for (int i = 0; i < 2; i++) ticks[i] += (tick[i] === 1'b1);

    t1p_ext_src u_src (.ref_clk(ref_clk), .ext_pin(ext_pin));

    t1p_top u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_io_space(reg_io),
        .reg_wr_en(reg_wr), .reg_rd_en(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(rdata),
        .global_irq_enable(gie), .capture_vector_ack(ack[3]), .match_b_vector_ack(ack[2]),
        .match_a_vector_ack(ack[1]), .wrap_vector_ack(ack[0]), .capture_irq_req_q(irq_c),
        .match_b_irq_req_q(irq_b), .match_a_irq_req_q(irq_a), .wrap_irq_req_q(irq_w),
        .waveform_mode_field(wmode), .capture_pin_event(ev[3]), .counter_top_event(ev[5]),
        .counter_overflow(ev[0]), .mode_wrap_event(ev[4]), .match_a_equal(ev[1]),
        .match_b_equal(ev[2]), .force_match_a_strobe(frc[0]), .force_match_b_strobe(frc[1]),
        .count_write(cwr), .timer0_clock_select(sel0), .timer1_clock_select(sel1),
        .external_count_pin(ext_pin), .prescaler_reset(psc_rst), .timer_tick_q(tick)
    );

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_io <= io;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic io, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_io <= io;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(rdata, exp);
    endtask : rdchk

    // one-cycle pulse on {top, mode wrap, capture, eq b, eq a, overflow}
    task automatic pulse(input logic [5:0] e, input logic [3:0] k);
        @(posedge ref_clk);
        ev <= e;
        ack <= k;
        @(posedge ref_clk);
        ev <= 6'h00;
        ack <= 4'h0;
        repeat (2) @(negedge ref_clk);
    endtask : pulse

    // ticks of both timers over a whole number of prescaler periods
    task automatic win(input int n, input int e0, input int e1);
        @(negedge ref_clk);
        #1 t0 = ticks;
        repeat (n) @(negedge ref_clk);
        #1;
        chk(ticks[0] - t0[0], e0);
        chk(ticks[1] - t0[1], e1);
    endtask : win

    task automatic end_sim;
        $display("checks %0d, errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        sel1 <= T1P_CS_SYS;
        gie <= 1'b1;
        rdchk(8'h36, 1'b0, 8'h00);
        rdchk(8'h6F, 1'b0, 8'h00);
        wr(8'h6F, 1'b0, 8'hFF);
        rdchk(8'h6F, 1'b0, 8'h27);
        rdchk(8'h55, 1'b0, 8'h00);
        pulse(6'h0F, 4'h0);
        chk({irq_c, irq_b, irq_a, irq_w}, 4'hF);
        rdchk(8'h16, 1'b1, 8'h27);
        gie <= 1'b0;
        pulse(6'h00, 4'hA);
        chk({irq_c, irq_b, irq_a, irq_w}, 4'h0);
        rdchk(8'h36, 1'b0, 8'h05);
        wr(8'h16, 1'b1, 8'hDD);
        rdchk(8'h36, 1'b0, 8'h00);
        wr(8'h6F, 1'b0, 8'h01);
        gie <= 1'b1;
        pulse(6'h0F, 4'h0);
        chk({irq_c, irq_b, irq_a, irq_w}, 4'h1);
        pulse(6'h00, 4'h5);
        chk({irq_c, irq_b, irq_a, irq_w}, 4'h0);
        wr(8'h36, 1'b0, 8'hFF);
        frc <= 2'h3;
        @(posedge ref_clk);
        frc <= 2'h0;
        rdchk(8'h36, 1'b0, 8'h00);
        cwr <= 1'b1;
        @(posedge ref_clk);
        cwr <= 1'b0;
        ev <= 6'h06;
        @(posedge ref_clk);
        ev <= 6'h00;
        rdchk(8'h36, 1'b0, 8'h00);
        ev <= 6'h01;
        wr(8'h36, 1'b0, 8'h01);
        ev <= 6'h00;
        rdchk(8'h36, 1'b0, 8'h01);
        wr(8'h36, 1'b0, 8'hFF);
        wmode <= 4'h8;
        pulse(6'h20, 4'h0);
        wmode <= 4'h1;
        pulse(6'h01, 4'h0);
        pulse(6'h10, 4'h0);
        rdchk(8'h36, 1'b0, 8'h21);
        for (int c = 1; c < 6; c++)
        begin
            sel1 <= t1p_clk_sel_t'(c);
            sel0 <= t1p_clk_sel_t'(6 - c);
            win(2048, 2048 / dv[6 - c], 2048 / dv[c]);
        end
        sel0 <= T1P_CS_STOP;
        sel1 <= T1P_CS_STOP;
        win(256, 0, 0);
        sel0 <= T1P_CS_DIV8;
        sel1 <= T1P_CS_DIV8;
        psc_rst <= 1'b1;
        win(256, 0, 0);
        psc_rst <= 1'b0;
        win(256, 32, 32);
        sel0 <= T1P_CS_EXT_FALL;
        sel1 <= T1P_CS_EXT_RISE;
        repeat (4) @(posedge ref_clk);
        fork
            u_src.pulses(5, 3);
            win(40, 5, 5);
        join
        end_sim;
    end

    // cut a hang well beyond the expected run of about 11100 cycles
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        err_total++;
        end_sim;
    end
endmodule : tb_top
